// ### design/led_driver_latch_write_control.sv
// Purpose: Serial shift register, on/off latch and function control latch
// Assumes: Shift clock i_sclk is a link clock; status flags are i_clk synchronous
// Notes:   Committed words cross to i_clk through a handshake and a 4-word FIFO
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Small FIFO
// ----------------------------------------------------------------
module latch_word_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // Fill side
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  // Flags and pointer updates
  always_comb begin
    o_ready     = (count != (AW+1)'(DEPTH)); // Full at exactly DEPTH words
    o_valid     = (count != '0);
    push        = i_valid && o_ready;
    pop         = o_valid && i_ready;
    next_wr_ptr = push ? AW'((wr_ptr + 1'b1) % DEPTH) : wr_ptr;
    next_rd_ptr = pop ? AW'((rd_ptr + 1'b1) % DEPTH) : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
    o_data      = mem[rd_ptr];
  end

  // Pointer and storage registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
      if (push) begin
        mem[wr_ptr] <= i_data;
      end
    end
  end
endmodule : latch_word_fifo

// ----------------------------------------------------------------
// Top
// ----------------------------------------------------------------
// Clocking overview
//   The shift register, the strobe synchroniser and the captured word
//   live on the serial clock. The latches, the status pick and the
//   decoded outputs live on the control clock.
// Strobe capture
//   The strobe pin passes two flip-flops on the serial clock, so its
//   rise is acted on two serial edges late. The shift register keeps
//   moving on those edges, so the word is taken from a two-deep copy
//   of the shift register that lines up with the synchroniser lag.
//   The word seen is the one present when the strobe pin rose.
// Crossing
//   A toggle request carries the captured word to the control clock.
//   The word is held still until the next strobe, long after the
//   toggle has been seen, so no bit of it is sampled while moving.
//   The FIFO drain side is always ready; latches follow one word per
//   control cycle, in strobe order.
// Status reload
//   The pick is frozen in a holding register on the control clock and
//   a toggle asks the serial side to load it. The serial clock must
//   keep running for a few edges after the latch update for the load
//   to land; a host that stops the clock too early sees it land on
//   the first edges of its next frame instead.
//   Only on/off writes raise the toggle, so the top bit of the shift
//   register at load time does not matter any more.
// Limitations
//   Back-to-back strobes closer than the crossing time overwrite the
//   captured word before the control side takes it, so the earlier word
//   is lost; the FIFO drains every control cycle and never fills to four.
// Contract
// - MSB zero strobe loads on/off latch
// - On/off update loads selected status
// - MSB one strobe loads control latch
// - Control write loads no status
// - Control latch resets to E67F
// - Bits 6:0 global brightness code
// - Bits 8:7 choose readback status source
// - Bits 10:9 short threshold select
// - Bits 12:11 hidden check current
// - Bits 14:13 hidden check time
// - Bit15 zero never power save
// - Bit15 one saves when all off
// - Serial clock shifts in, MSB out
// - Shift register resets to zero
// - Blanking forces outputs off, latch kept
// - On/off latch resets to zero
module led_driver_latch_write_control
  import led_latch_pkg::*;
(
  // Clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_n,
  // Serial link
  input  wire logic                        i_sclk,
  input  wire logic                        i_serial_in,
  input  wire logic                        i_latch_strobe,
  output logic                             o_serial_out,
  // Output control
  input  wire logic                        i_blank,
  output logic [led_latch_pkg::DATA_W-1:0] o_sink_output,
  // Status inputs
  input  wire led_latch_pkg::status_flags_t i_status,
  // Decoded control
  output led_latch_pkg::ctrl_fields_t      o_ctrl,
  output logic [7:0]                       o_hidden_check_clocks,
  output logic                             o_hidden_check_mode,
  output logic                             o_power_save,
  output logic                             o_word_ready
);
  import led_latch_pkg::*;

  logic [SHIFT_W-1:0] shift_reg;
  logic [SHIFT_W-1:0] next_shift_reg;
  logic [1:0]         strobe_sync;
  logic               strobe_prev;
  logic               strobe_rise;
  logic               req_tgl;
  logic               next_req_tgl;
  logic [DATA_W-1:0]  status_hold;
  logic               status_load;
  latch_word_t        cap_word;
  latch_word_t        next_cap_word;
  logic [SHIFT_W-1:0] shift_d1;
  logic [SHIFT_W-1:0] shift_d2;
  logic [2:0]         req_sync;
  logic               ack_tgl;
  logic               fifo_in_valid;
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  latch_word_t        fifo_out;
  logic [DATA_W-1:0]  onoff_latch;
  logic [DATA_W-1:0]  next_onoff_latch;
  logic [DATA_W-1:0]  ctrl_latch;
  logic [DATA_W-1:0]  next_ctrl_latch;
  logic [1:0]         blank_sync;
  logic [DATA_W-1:0]  next_status_hold;
  logic               next_status_load;
  logic [1:0]         load_sync;
  logic               load_prev;
  logic [DATA_W-1:0]  status_pick;

  // Link: strobe edge seen on serial clock, shifting and status reload
  always_comb begin
    strobe_rise   = strobe_sync[1] && !strobe_prev;
    next_req_tgl  = req_tgl;
    next_cap_word = cap_word;
    next_shift_reg = {shift_reg[SHIFT_W-2:0], i_serial_in};
    // Word as it stood when the strobe pin rose, two shifts ago
    if (strobe_rise) begin
      next_cap_word = '{to_ctrl: shift_d2[SEL_TOP], data: shift_d2[DATA_W-1:0]};
      next_req_tgl  = !req_tgl;
    end
    // Status load request comes only from on/off writes
    if (load_sync[1] != load_prev) begin
      next_shift_reg = {shift_reg[SEL_TOP], status_hold};
    end
  end

  // Link registers on the serial clock
  always_ff @(posedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_reg   <= SHIFT_RESET;
      shift_d1    <= SHIFT_RESET;
      shift_d2    <= SHIFT_RESET;
      strobe_sync <= '0;
      strobe_prev <= 1'b0;
      req_tgl     <= 1'b0;
      cap_word    <= '0;
      load_sync   <= '0;
      load_prev   <= 1'b0;
    end else begin
      shift_reg   <= next_shift_reg;
      shift_d1    <= shift_reg;
      shift_d2    <= shift_d1;
      strobe_sync <= {strobe_sync[0], i_latch_strobe};
      strobe_prev <= strobe_sync[1];
      req_tgl     <= next_req_tgl;
      cap_word    <= next_cap_word;
      load_sync   <= {load_sync[0], status_load};
      load_prev   <= load_sync[1];
    end
  end

  assign o_serial_out = shift_reg[SEL_TOP];

  // Control side: toggle synchroniser feeding the FIFO
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_sync   <= '0;
      ack_tgl    <= 1'b0;
      blank_sync <= '0;
    end else begin
      req_sync   <= {req_sync[1:0], req_tgl};
      ack_tgl    <= (fifo_in_valid && fifo_in_ready) ? !ack_tgl : ack_tgl;
      blank_sync <= {blank_sync[0], i_blank};
    end
  end

  assign fifo_in_valid = (req_sync[2] != req_sync[1]) || (ack_tgl != req_sync[1]);
  assign o_word_ready  = fifo_in_ready;

  latch_word_fifo #(
    .WIDTH ($bits(latch_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_valid (fifo_in_valid && (ack_tgl != req_sync[1])),
    .o_ready (fifo_in_ready),
    .i_data  (cap_word),
    .o_valid (fifo_out_valid),
    .i_ready (1'b1),
    .o_data  (fifo_out)
  );

  // Readback status chosen by the status select field
  always_comb begin
    case (ctrl_latch[STSEL_HI:STSEL_LO])
      STSEL_OPEN:  status_pick = i_status.thermal_error_flag ? '1 : i_status.open_led_flag;
      STSEL_SHORT: status_pick = i_status.thermal_warning_flag ? '1 : i_status.shorted_led_flag;
      STSEL_LEAK:  status_pick = i_status.ref_short_flag ? '1 : i_status.leakage_flag;
      default:     status_pick = '0;
    endcase
  end

  // Latch updates from committed words
  always_comb begin
    next_onoff_latch = onoff_latch;
    next_ctrl_latch  = ctrl_latch;
    next_status_hold = status_hold;
    next_status_load = status_load;
    if (fifo_out_valid) begin
      if (fifo_out.to_ctrl) begin
        next_ctrl_latch = fifo_out.data;
      end else begin
        next_onoff_latch = fifo_out.data;
        if (ctrl_latch[STSEL_HI:STSEL_LO] != STSEL_NONE) begin
          next_status_hold = status_pick;
          next_status_load = !status_load;
        end
      end
    end
  end

  // Latch registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      onoff_latch <= ONOFF_RESET;
      ctrl_latch  <= CTRL_RESET;
      status_hold <= '0;
      status_load <= 1'b0;
    end else begin
      onoff_latch <= next_onoff_latch;
      ctrl_latch  <= next_ctrl_latch;
      status_hold <= next_status_hold;
      status_load <= next_status_load;
    end
  end

  // Decoded outputs
  always_comb begin
    o_ctrl        = ctrl_fields_t'(ctrl_latch);
    o_sink_output = blank_sync[1] ? '0 : onoff_latch;
    o_hidden_check_mode = (ctrl_latch[HCUR_HI:HCUR_LO] != 2'h0);
    o_power_save  = ctrl_latch[PSAVE_BIT] && (onoff_latch == '0);
    case (ctrl_latch[HTIM_HI:HTIM_LO])
      2'h0:    o_hidden_check_clocks = HTIM_CLK0;
      2'h1:    o_hidden_check_clocks = HTIM_CLK1;
      2'h2:    o_hidden_check_clocks = HTIM_CLK2;
      default: o_hidden_check_clocks = HTIM_CLK3;
    endcase
  end
endmodule : led_driver_latch_write_control

`default_nettype wire

// ### design/led_latch_pkg.sv
// Purpose: Shared constants and types for the LED driver serial latch block
// Assumes: Serial link runs on its own clock; control side on i_clk
// Notes:   Field positions, defaults and codes of the control latch
package led_latch_pkg;
  localparam int SHIFT_W = 17;
  localparam int DATA_W  = 16;
  localparam int SEL_TOP = 16;
  localparam logic [15:0] CTRL_RESET   = 16'hE67F;
  localparam logic [15:0] ONOFF_RESET  = 16'h0000;
  localparam logic [16:0] SHIFT_RESET  = 17'h00000;
  localparam int BRIGHT_LO = 0;
  localparam int BRIGHT_HI = 6;
  localparam int STSEL_LO  = 7;
  localparam int STSEL_HI  = 8;
  localparam int SHORT_LO  = 9;
  localparam int SHORT_HI  = 10;
  localparam int HCUR_LO   = 11;
  localparam int HCUR_HI   = 12;
  localparam int HTIM_LO   = 13;
  localparam int HTIM_HI   = 14;
  localparam int PSAVE_BIT = 15;
  localparam int FIFO_DEPTH = 4;

  typedef enum logic [1:0] {
    STSEL_NONE  = 2'h0,
    STSEL_OPEN  = 2'h1,
    STSEL_SHORT = 2'h2,
    STSEL_LEAK  = 2'h3
  } status_sel_t;

  // Oscillator clocks of the hidden check window per time code
  localparam logic [7:0] HTIM_CLK0 = 8'h11;
  localparam logic [7:0] HTIM_CLK1 = 8'h21;
  localparam logic [7:0] HTIM_CLK2 = 8'h41;
  localparam logic [7:0] HTIM_CLK3 = 8'h81;

  // Decoded control latch fields
  typedef struct packed {
    logic        power_save_enable;
    logic [1:0]  hidden_check_time;
    logic [1:0]  hidden_check_current;
    logic [1:0]  short_threshold_select;
    status_sel_t status_select;
    logic [6:0]  global_brightness_code;
  } ctrl_fields_t;

  // Status flag sets offered for readback
  typedef struct packed {
    logic [15:0] open_led_flag;
    logic [15:0] shorted_led_flag;
    logic [15:0] leakage_flag;
    logic        thermal_error_flag;
    logic        thermal_warning_flag;
    logic        ref_short_flag;
  } status_flags_t;

  // One committed latch word carried across domains
  typedef struct packed {
    logic        to_ctrl;
    logic [15:0] data;
  } latch_word_t;
endpackage : led_latch_pkg

// ### tb/led_latch_props.sv
// Purpose: Port checks of the LED latch block
// Assumes: Control outputs settle on i_clk
// Notes:   Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module led_latch_props
  import led_latch_pkg::*;
(
  input wire logic                i_clk,
  input wire logic                i_rst_n,
  input wire logic                i_blank,
  input wire logic                o_serial_out,
  input wire logic [15:0]         o_sink_output,
  input wire ctrl_fields_t        o_ctrl,
  input wire logic [7:0]          o_hidden_check_clocks,
  input wire logic                o_hidden_check_mode,
  input wire logic                o_power_save
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Window length per time code
  function automatic logic [7:0] clk_of(input logic [1:0] c);
    return (c == 2'h0) ? HTIM_CLK0 : (c == 2'h1) ? HTIM_CLK1 : (c == 2'h2) ? HTIM_CLK2 : HTIM_CLK3;
  endfunction : clk_of
  sequence s_blank_held; i_blank [*3]; endsequence
  sequence s_ctrl_quiet; $stable(o_ctrl) [*3]; endsequence
  property p_ctrl_rst; $rose(i_rst_n) |-> o_ctrl == CTRL_RESET; endproperty
  property p_sink_rst; $rose(i_rst_n) |-> o_sink_output == 16'h0000; endproperty
  property p_serial_out_rst; $rose(i_rst_n) |-> !o_serial_out; endproperty
  property p_clocks; $stable(o_ctrl) |-> o_hidden_check_clocks == clk_of(o_ctrl.hidden_check_time); endproperty
  property p_mode; $stable(o_ctrl) |-> o_hidden_check_mode == (o_ctrl.hidden_check_current != 2'h0); endproperty
  property p_psave_en; $stable(o_ctrl) && o_power_save |-> o_ctrl.power_save_enable; endproperty
  property p_psave_off; o_power_save |-> o_sink_output == 16'h0000; endproperty
  property p_blank; s_blank_held |=> o_sink_output == 16'h0000; endproperty
  property p_one_update; $changed(o_ctrl) |=> s_ctrl_quiet; endproperty
  a_ctrl_rst: assert property (p_ctrl_rst) else $error("control latch not at default");
  a_sink_rst: assert property (p_sink_rst) else $error("outputs not off after reset");
  a_serial_out_rst: assert property (p_serial_out_rst) else $error("serial out not low after reset");
  a_clocks: assert property (p_clocks) else $error("check window length wrong");
  a_mode: assert property (p_mode) else $error("check mode does not follow current code");
  a_psave_en: assert property (p_psave_en) else $error("power save while disabled");
  a_psave_off: assert property (p_psave_off) else $error("power save with outputs on");
  a_blank: assert property (p_blank) else $error("blank did not force outputs off");
  a_one_update: assert property (p_one_update) else $error("control latch moved twice");
endmodule : led_latch_props
bind led_driver_latch_write_control led_latch_props i_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_blank(i_blank), .o_serial_out(o_serial_out), .o_sink_output(o_sink_output), .o_ctrl(o_ctrl),
  .o_hidden_check_clocks(o_hidden_check_clocks), .o_hidden_check_mode(o_hidden_check_mode),
  .o_power_save(o_power_save));
`default_nettype wire

// ### tb/led_host_model.sv
// Purpose: Host controller shifting words into the driver
// Assumes: Link clock of 6 ns, still between frames
// Notes:   Data line toggles once released
`timescale 1ns/1ps
`default_nettype none
module led_host_model (
  output logic o_sclk,
  output logic o_sin,
  output logic o_strobe
);
  // Run-out edges cover strobe sync, crossing and status reload
  localparam int RUN_OUT = 20;
  initial begin
    o_sclk = 1'b0;
    o_sin = 1'b0;
    o_strobe = 1'b0;
  end
  // Whole word MSB first, strobe only after the last bit, then run-out edges
  task automatic send(input logic [16:0] w);
    for (int i = 16; i >= 0; i--) begin
      o_sin = w[i];
      #3 o_sclk = 1'b1;
      #3 o_sclk = 1'b0;
    end
    o_strobe = 1'b1;
    repeat (RUN_OUT) begin
      o_sin = ~o_sin;
      #3 o_sclk = 1'b1;
      #3 o_sclk = 1'b0;
    end
    o_strobe = 1'b0;
  endtask : send
endmodule : led_host_model
`default_nettype wire

// ### tb/testbench.sv
// Purpose: Random and corner writes of both latches
// Assumes: Latches settle within 20 control cycles of a frame
// Notes:   Expected latch images kept by the bench
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import led_latch_pkg::*;
  logic          clk;
  logic          rst_n;
  logic          blank;
  logic          sclk;
  logic          serial_in;
  logic          strobe;
  logic          serial_out;
  logic          hmode;
  logic          psave;
  logic          wrdy;
  logic [7:0]    hclk;
  logic [15:0]   sink;
  logic [63:0]   r;
  status_flags_t status;
  ctrl_fields_t  ctrl;
  int            miscompares = 0;
  int            n_checks = 0;
  logic [15:0]   e_ctrl = CTRL_RESET;
  logic [15:0]   e_on = ONOFF_RESET;
  logic [16:0]   corner [7] = '{17'h10000, 17'h00000, 17'h18000, 17'h10080, 17'h0A5A5, 17'h10180, 17'h1E67F};
  led_host_model i_host (.o_sclk(sclk), .o_sin(serial_in), .o_strobe(strobe));
  led_driver_latch_write_control i_led_driver_latch_write_control (.i_clk(clk), .i_rst_n(rst_n),
    .i_sclk(sclk), .i_serial_in(serial_in), .i_latch_strobe(strobe), .o_serial_out(serial_out), .i_blank(blank),
    .o_sink_output(sink), .i_status(status), .o_ctrl(ctrl), .o_hidden_check_clocks(hclk),
    .o_hidden_check_mode(hmode), .o_power_save(psave), .o_word_ready(wrdy));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Expected power save from the bench images
  function automatic logic exp_ps();
    return e_ctrl[PSAVE_BIT] && (e_on == 16'h0000);
  endfunction : exp_ps
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // One frame, then compare control, sink, power save and ready outputs
  task automatic put(input logic [16:0] w);
    r = {$urandom(), $urandom()};
    status = r[50:0];
    i_host.send(w);
    repeat (20) @(posedge clk);
    #1;
    if (w[SEL_TOP]) e_ctrl = w[15:0];
    else e_on = w[15:0];
    chk("ctrl", e_ctrl, ctrl);
    chk("sink", e_on, sink);
    chk("psave", {15'h0, exp_ps()}, {15'h0, psave});
    chk("ready", 16'h0001, {15'h0, wrdy});
  endtask : put
  initial begin
    rst_n = 1'b0;
    blank = 1'b0;
    status = '0;
    void'($urandom(59159));
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    @(posedge clk);
    #1;
    chk("ctrl_rst", CTRL_RESET, ctrl);
    chk("sink_rst", ONOFF_RESET, sink);
    chk("serial_out_rst", 16'h0000, {15'h0, serial_out});
    foreach (corner[i]) put(corner[i]);
    repeat (12) put(17'($urandom()));
    put(17'h0FFFF);
    blank = 1'b1;
    repeat (5) @(posedge clk);
    #1 chk("blank_on", 16'h0000, sink);
    blank = 1'b0;
    repeat (5) @(posedge clk);
    #1 chk("blank_off", e_on, sink);
    print_verdict();
  end
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
